// *** rtl/interrupt_source_vector_unit.sv ***
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - Instruction traps ignore enable flag and priority
// - Undefined opcode raises undefined-instruction interrupt
// - Overflow trap fires only with overflow flag 1
// - Arithmetic instructions update overflow flag
// - Overflow vector from fixed slot FFFE0
// - Breakpoint trap raises breakpoint interrupt
// - Numbered trap 0..63 uses relocatable entry
// - Numbers 4..31 share peripheral vectors
// - Traps 0..31 push, clear stack select
// - Traps 32..63 leave stack select alone
// - Maskable: gated by enable, programmable priority
// - Special hardware sources are non-maskable
// - Watchdog timer sources the watchdog interrupt
// - Enabled address match fires before instruction
// - Peripheral requests maskable, relocatable vectors
// - Vector is four bytes, low first
// - Program counter loaded from selected vector
// - Fixed table spans FFFDC to FFFFF
// - Fixed vector high bytes give ID data
// - Relocatable table 256 bytes, entry 4n
module interrupt_source_vector_unit
	import isvu_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write channels
	input wire logic awvalid,
	output logic awready,
	input wire logic [7:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// AXI4-Lite read channels
	input wire logic arvalid,
	output logic arready,
	input wire logic [7:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	// Trapping instructions from the core
	input wire logic exec_valid,
	output logic exec_ready,
	input wire exec_req_t exec_req,
	input wire logic arith_valid,
	input wire logic arith_overflow,
	output logic overflow_flag,
	// Stack-pointer select flag
	output logic sp_select,
	output logic sp_push_valid,
	output logic sp_push_value,
	input wire logic ret_restore,
	input wire logic ret_sp_select,
	// Special hardware sources
	input wire logic debugger_break_interrupt,
	input wire logic watchdog_event,
	input wire logic single_step_event,
	input wire logic fetch_valid,
	input wire logic [19:0] fetch_addr,
	output logic match_hit,
	// Peripheral requests
	input wire logic global_enable,
	input wire logic [2:0] cpu_level,
	input wire logic periph_valid,
	input wire logic [5:0] periph_number,
	input wire logic [2:0] periph_level,
	output logic periph_ack,
	// Vector byte reads
	output logic mem_req,
	output logic [19:0] mem_addr,
	input wire logic mem_ack,
	input wire logic [7:0] mem_rdata,
	// Program counter load
	output logic pc_load,
	output logic [19:0] pc_value,
	output logic [7:0] id_byte
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	state_t state_q;
	logic boot_q, ovf_flag_q, sp_sel_q, push_q, push_val_q;
	logic dbc_pend_q, wdt_pend_q, step_pend_q, match_pend_q;
	logic fixed_q;
	logic [1:0] cnt_q;
	logic [19:0] addr_q;
	logic [31:0] vector_q;
	logic [7:0] id_q;
	logic [19:0] match_addr_q [4];
	logic [1:0] en_a_q, en_b_q;
	logic [19:0] tbase_q;

	// ----------------------------------------------------------------
	// Source selection
	// ----------------------------------------------------------------
	// Instruction traps win over everything but the reset fetch;
	// they never look at the enable flag or levels.
	wire idle = (state_q == ST_IDLE);
	wire exec_take = exec_valid & exec_ready;
	wire take_und = exec_take & (exec_req.kind == EX_UND);
	wire take_ovf = exec_take & (exec_req.kind == EX_OVF) & ovf_flag_q;
	wire take_brk = exec_take & (exec_req.kind == EX_BRK);
	wire take_num = exec_take & (exec_req.kind == EX_NUM);
	wire num_low = take_num & (exec_req.number < SP_KEEP_FIRST);
	wire hw_idle = idle & ~boot_q & ~exec_valid;
	wire take_boot = idle & boot_q;
	wire take_dbc = hw_idle & dbc_pend_q;
	wire take_wdt = hw_idle & ~dbc_pend_q & wdt_pend_q;
	wire take_step = hw_idle & ~dbc_pend_q & ~wdt_pend_q & step_pend_q;
	wire take_match = hw_idle & ~dbc_pend_q & ~wdt_pend_q & ~step_pend_q & match_pend_q;
	wire nmi_any = dbc_pend_q | wdt_pend_q | step_pend_q | match_pend_q;
	// Only the maskable path sees the enable flag and levels
	wire periph_ok = global_enable & (periph_level > cpu_level);
	wire take_periph = hw_idle & ~nmi_any & periph_valid & periph_ok;
	wire start_fixed = take_und | take_ovf | take_boot | take_dbc | take_wdt
		| take_step | take_match;
	wire start_reloc = take_num | take_periph;
	wire [3:0] fixed_slot = take_boot ? SLOT_RESET :
		take_und ? SLOT_UND :
		take_ovf ? SLOT_OVF :
		take_dbc ? SLOT_DBC :
		take_wdt ? SLOT_WDT :
		take_step ? SLOT_STEP : SLOT_MATCH;
	wire [19:0] fixed_addr = FIXED_BASE + {14'h0000, fixed_slot, 2'b00};
	wire [5:0] reloc_num = take_num ? exec_req.number : periph_number;
	// Entry offset is 4n inside a 256-byte window
	wire [19:0] reloc_addr = tbase_q + {12'h000, reloc_num, 2'b00};
	wire [19:0] brk_reloc = tbase_q + {12'h000, BRK_NUMBER, 2'b00};
	wire [19:0] brk_fixed = FIXED_BASE + {14'h0000, SLOT_BRK, 2'b00};
	wire byte_done = (state_q == ST_FETCH) & mem_ack;
	wire last_byte = byte_done & (cnt_q == LAST_BYTE);

	assign exec_ready = idle & ~boot_q;
	assign periph_ack = take_periph;
	assign mem_req = (state_q == ST_CHECK) | (state_q == ST_FETCH);
	assign mem_addr = addr_q;
	assign pc_load = (state_q == ST_LOAD);
	assign pc_value = vector_q[19:0];
	assign id_byte = id_q;
	assign overflow_flag = ovf_flag_q;
	assign sp_select = sp_sel_q;
	assign sp_push_valid = push_q;
	assign sp_push_value = push_val_q;

	// ----------------------------------------------------------------
	// Address match
	// ----------------------------------------------------------------
	wire [3:0] match_en = {en_b_q, en_a_q};
	wire [3:0] match_eq;
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_match
			assign match_eq[gi] = match_en[gi] & (fetch_addr == match_addr_q[gi]);
		end
	endgenerate
	assign match_hit = fetch_valid & (|match_eq);

	// ----------------------------------------------------------------
	// Flags and pending special sources
	// ----------------------------------------------------------------
	// A new event in the service cycle re-arms the bit, so set wins
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			dbc_pend_q <= 1'b0;
			wdt_pend_q <= 1'b0;
			step_pend_q <= 1'b0;
			match_pend_q <= 1'b0;
			ovf_flag_q <= 1'b0;
		end
		else
		begin
			dbc_pend_q <= debugger_break_interrupt | (dbc_pend_q & ~take_dbc);
			wdt_pend_q <= watchdog_event | (wdt_pend_q & ~take_wdt);
			step_pend_q <= single_step_event | (step_pend_q & ~take_step);
			match_pend_q <= match_hit | (match_pend_q & ~take_match);
			if (arith_valid)
				ovf_flag_q <= arith_overflow;
		end
	end

	// Stack-pointer select: saved and cleared for low trap numbers
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sp_sel_q <= 1'b0;
			push_q <= 1'b0;
			push_val_q <= 1'b0;
		end
		else
		begin
			push_q <= num_low;
			if (num_low)
			begin
				push_val_q <= sp_sel_q;
				sp_sel_q <= 1'b0;
			end
			else if (ret_restore)
				sp_sel_q <= ret_sp_select;
		end
	end

	// ----------------------------------------------------------------
	// Vector fetch sequencer
	// ----------------------------------------------------------------
	// Reset vector is fetched first after every reset
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_q <= ST_IDLE;
			boot_q <= 1'b1;
			fixed_q <= 1'b0;
			cnt_q <= 2'h0;
			addr_q <= RST_ADDR20;
		end
		else
		begin
			case (state_q)
				ST_IDLE:
				begin
					cnt_q <= 2'h0;
					if (take_boot)
						boot_q <= 1'b0;
					if (start_fixed)
					begin
						state_q <= ST_FETCH;
						fixed_q <= 1'b1;
						addr_q <= fixed_addr;
					end
					else if (take_brk)
					begin
						state_q <= ST_CHECK;
						addr_q <= BRK_MARK_ADDR;
					end
					else if (start_reloc)
					begin
						state_q <= ST_FETCH;
						fixed_q <= 1'b0;
						addr_q <= reloc_addr;
					end
				end
				ST_CHECK:
					if (mem_ack)
					begin
						state_q <= ST_FETCH;
						fixed_q <= (mem_rdata != BRK_MARK_VAL);
						addr_q <= (mem_rdata == BRK_MARK_VAL) ? brk_reloc : brk_fixed;
					end
				ST_FETCH:
					if (mem_ack)
					begin
						cnt_q <= cnt_q + 2'h1;
						addr_q <= addr_q + 20'h00001;
						if (last_byte)
							state_q <= ST_LOAD;
					end
				ST_LOAD:
					state_q <= ST_IDLE;
				default:
					state_q <= ST_IDLE;
			endcase
		end
	end

	// Bytes land low address first into the vector word
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			vector_q <= 32'h00000000;
			id_q <= 8'h00;
		end
		else if (byte_done)
		begin
			vector_q[cnt_q*8 +: 8] <= mem_rdata;
			if (last_byte & fixed_q)
				id_q <= mem_rdata;
		end
	end

	// ----------------------------------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------------------------------
	// Address and data may come in either order; each is held here
	logic aw_have_q, w_have_q, bvalid_q, rvalid_q;
	logic [7:0] aw_addr_q;
	logic [31:0] w_data_q, rdata_q;
	logic [3:0] w_strb_q;
	logic [1:0] bresp_q, rresp_q;

	function automatic logic [19:0] merge20(input logic [19:0] old, input logic [31:0] d,
		input logic [3:0] s);
		logic [31:0] m;
		m = {12'h000, old};
		for (int i = 0; i < 4; i++)
			if (s[i])
				m[i*8 +: 8] = d[i*8 +: 8];
		return m[19:0];
	endfunction : merge20

	wire do_write = aw_have_q & w_have_q & ~bvalid_q;
	wire wsel_m = do_write & (aw_addr_q[7:4] == OFS_MATCH0[7:4]);
	wire wsel_a = do_write & (aw_addr_q[7:2] == OFS_EN_A[7:2]);
	wire wsel_b = do_write & (aw_addr_q[7:2] == OFS_EN_B[7:2]);
	wire wsel_t = do_write & (aw_addr_q[7:2] == OFS_TBASE[7:2]);
	wire wsel_ro = (aw_addr_q[7:2] == OFS_STATUS[7:2]) | (aw_addr_q[7:2] == OFS_VECTOR[7:2])
		| (aw_addr_q[7:2] == OFS_IDBYTE[7:2]);
	wire w_mapped = (aw_addr_q[7:4] == OFS_MATCH0[7:4]) | (aw_addr_q[7:2] == OFS_EN_A[7:2])
		| (aw_addr_q[7:2] == OFS_EN_B[7:2]) | (aw_addr_q[7:2] == OFS_TBASE[7:2]) | wsel_ro;
	wire [1:0] widx = aw_addr_q[3:2];
	wire [31:0] status_w = {24'h000000, nmi_any, sp_sel_q, ovf_flag_q, boot_q,
		match_pend_q, 1'b0, state_q};
	wire [5:0] ridx = araddr[7:2];
	wire r_mapped = (araddr[7:2] <= OFS_IDBYTE[7:2]);
	wire [31:0] rd_word =
		(ridx == OFS_EN_A[7:2]) ? {30'h00000000, en_a_q} :
		(ridx == OFS_EN_B[7:2]) ? {30'h00000000, en_b_q} :
		(ridx == OFS_TBASE[7:2]) ? {12'h000, tbase_q} :
		(ridx == OFS_STATUS[7:2]) ? status_w :
		(ridx == OFS_VECTOR[7:2]) ? vector_q :
		(ridx == OFS_IDBYTE[7:2]) ? {24'h000000, id_q} :
		(ridx[5:2] == 4'h0) ? {12'h000, match_addr_q[ridx[1:0]]} : 32'h00000000;

	assign awready = ~aw_have_q;
	assign wready = ~w_have_q;
	assign bvalid = bvalid_q;
	assign bresp = bresp_q;
	assign arready = ~rvalid_q;
	assign rvalid = rvalid_q;
	assign rdata = rdata_q;
	assign rresp = rresp_q;

	// Write channel bookkeeping
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
			aw_addr_q <= 8'h00;
			w_data_q <= 32'h00000000;
			w_strb_q <= 4'h0;
		end
		else
		begin
			if (awvalid & awready)
			begin
				aw_have_q <= 1'b1;
				aw_addr_q <= awaddr;
			end
			if (wvalid & wready)
			begin
				w_have_q <= 1'b1;
				w_data_q <= wdata;
				w_strb_q <= wstrb;
			end
			if (do_write)
			begin
				bvalid_q <= 1'b1;
				bresp_q <= w_mapped ? RESP_OKAY : RESP_SLVERR;
			end
			else if (bvalid_q & bready)
			begin
				bvalid_q <= 1'b0;
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
			end
		end
	end

	// Software-visible configuration; read-only words ignore writes
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			for (int i = 0; i < 4; i++)
				match_addr_q[i] <= RST_ADDR20;
			en_a_q <= RST_EN;
			en_b_q <= RST_EN;
			tbase_q <= RST_ADDR20;
		end
		else
		begin
			if (wsel_m)
				match_addr_q[widx] <= merge20(match_addr_q[widx], w_data_q, w_strb_q);
			if (wsel_a & w_strb_q[0])
				en_a_q <= w_data_q[1:0];
			if (wsel_b & w_strb_q[0])
				en_b_q <= w_data_q[1:0];
			if (wsel_t)
				tbase_q <= merge20(tbase_q, w_data_q, w_strb_q);
		end
	end

	// Read channel: answer one cycle after the address is taken
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h00000000;
			rresp_q <= RESP_OKAY;
		end
		else if (arvalid & arready)
		begin
			rvalid_q <= 1'b1;
			rdata_q <= rd_word;
			rresp_q <= r_mapped ? RESP_OKAY : RESP_SLVERR;
		end
		else if (rready)
			rvalid_q <= 1'b0;
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_four_bytes;
		(state_q == ST_FETCH) ##0 (mem_ack && cnt_q == LAST_BYTE);
	endsequence

	und_vector_a: assert property (take_und |=> addr_q == 20'hFFFDC)
		else $error("undefined trap did not select its fixed slot");
	ovf_gate_a: assert property (exec_take && exec_req.kind == EX_OVF && !ovf_flag_q
		|=> state_q == ST_IDLE)
		else $error("overflow trap fired with flag clear");
	ovf_vector_a: assert property (take_ovf |=> state_q == ST_FETCH && addr_q == 20'hFFFE0)
		else $error("overflow vector slot wrong");
	brk_check_a: assert property (take_brk |=> state_q == ST_CHECK && addr_q == 20'hFFFE7)
		else $error("breakpoint did not check marker byte");
	brk_reloc_a: assert property (state_q == ST_CHECK && mem_ack && mem_rdata == 8'hFF
		|=> addr_q == $past(tbase_q) && !fixed_q)
		else $error("breakpoint fallback not taken");
	sp_clear_a: assert property (num_low |=> !sp_sel_q && push_q && push_val_q == $past(sp_sel_q))
		else $error("stack select not saved and cleared");
	sp_keep_a: assert property (take_num && exec_req.number >= SP_KEEP_FIRST && !ret_restore
		|=> $stable(sp_sel_q) && !push_q)
		else $error("stack select changed for high trap");
	mask_gate_a: assert property (periph_ack |-> global_enable && periph_level > cpu_level)
		else $error("maskable request taken while masked");
	nmi_ungated_a: assert property (hw_idle && wdt_pend_q && !dbc_pend_q
		|=> state_q == ST_FETCH && addr_q == 20'hFFFF0)
		else $error("watchdog interrupt blocked");
	pc_load_a: assert property (s_four_bytes |=> pc_load && vector_q[31:24] == $past(mem_rdata)
		&& pc_value == $past(vector_q[19:0]))
		else $error("vector high byte not loaded before program counter");
	match_arm_a: assert property (match_hit |=> match_pend_q)
		else $error("address match not latched");

endmodule : interrupt_source_vector_unit
`default_nettype wire

// *** rtl/isvu_pkg.sv ***
package isvu_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses, one aligned word each)
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_MATCH0 = 8'h00;
	localparam logic [7:0] OFS_MATCH1 = 8'h04;
	localparam logic [7:0] OFS_MATCH2 = 8'h08;
	localparam logic [7:0] OFS_MATCH3 = 8'h0C;
	localparam logic [7:0] OFS_EN_A = 8'h10;
	localparam logic [7:0] OFS_EN_B = 8'h14;
	localparam logic [7:0] OFS_TBASE = 8'h18;
	localparam logic [7:0] OFS_STATUS = 8'h1C;
	localparam logic [7:0] OFS_VECTOR = 8'h20;
	localparam logic [7:0] OFS_IDBYTE = 8'h24;
	localparam logic [19:0] RST_ADDR20 = 20'h00000;
	localparam logic [1:0] RST_EN = 2'h0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------------
	// Vector tables
	// ----------------------------------------------------------------
	localparam logic [19:0] FIXED_BASE = 20'hFFFDC;
	localparam logic [19:0] FIXED_LAST = 20'hFFFFF;
	localparam logic [19:0] BRK_MARK_ADDR = 20'hFFFE7;
	localparam logic [7:0] BRK_MARK_VAL = 8'hFF;
	localparam logic [3:0] SLOT_UND = 4'h0;
	localparam logic [3:0] SLOT_OVF = 4'h1;
	localparam logic [3:0] SLOT_BRK = 4'h2;
	localparam logic [3:0] SLOT_MATCH = 4'h3;
	localparam logic [3:0] SLOT_STEP = 4'h4;
	localparam logic [3:0] SLOT_WDT = 4'h5;
	localparam logic [3:0] SLOT_DBC = 4'h6;
	localparam logic [3:0] SLOT_RESET = 4'h8;
	localparam logic [5:0] SP_KEEP_FIRST = 6'h20;
	localparam logic [5:0] BRK_NUMBER = 6'h00;
	localparam logic [1:0] LAST_BYTE = 2'h3;

	// Kinds of trapping instruction reported by the core
	typedef enum logic [1:0] {
		EX_UND = 2'b00,
		EX_OVF = 2'b01,
		EX_BRK = 2'b10,
		EX_NUM = 2'b11
	} exec_kind_t;

	typedef struct packed {
		exec_kind_t kind;
		logic [5:0] number;
	} exec_req_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_CHECK = 2'b01,
		ST_FETCH = 2'b10,
		ST_LOAD = 2'b11
	} state_t;

endpackage : isvu_pkg

// *** sim/tb_interrupt_source_vector_unit.sv ***
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, act) begin total_checks++; if ((act) !== (exp)) begin n_fail++; \
	$display("Error %s expected %h seen %h", nm, exp, act); end end
module tb_interrupt_source_vector_unit
	import isvu_pkg::*;
;
	logic aclk = 1'b0;
	logic aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready;
	logic rvalid, exec_valid, exec_ready, arith_valid, arith_overflow, overflow_flag;
	logic [7:0] awaddr, araddr, mem_rdata, id_byte, brk_mark;
	logic [31:0] wdata, rdata, d;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, r;
	exec_req_t exec_req;
	logic sp_select, sp_push_valid, sp_push_value, ret_restore, ret_sp_select, last_push;
	logic debugger_break_interrupt, watchdog_event, single_step_event, fetch_valid, match_hit;
	logic [19:0] fetch_addr, mem_addr, pc_value;
	logic global_enable, periph_valid, periph_ack, mem_req, mem_ack, pc_load;
	logic [2:0] cpu_level, periph_level, latency;
	logic [5:0] periph_number;
	logic [19:0] tbase = 20'h40000;
	int n_fail = 0;
	int total_checks = 0;
	int pushes = 0;
	int p;
	int nums[5] = '{0, 5, 31, 32, 63};
	logic [19:0] spec[3] = '{20'hFFFF4, 20'hFFFF0, 20'hFFFEC};

	// Design and its memory partner
	interrupt_source_vector_unit dut (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid,
		.wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid,
		.rready, .rdata, .rresp, .exec_valid, .exec_ready, .exec_req, .arith_valid,
		.arith_overflow, .overflow_flag, .sp_select, .sp_push_valid, .sp_push_value,
		.ret_restore, .ret_sp_select, .debugger_break_interrupt, .watchdog_event,
		.single_step_event, .fetch_valid, .fetch_addr, .match_hit, .global_enable, .cpu_level,
		.periph_valid, .periph_number, .periph_level, .periph_ack, .mem_req, .mem_addr,
		.mem_ack, .mem_rdata, .pc_load, .pc_value, .id_byte);
	vector_memory_model mem (.aclk, .aresetn, .mem_req, .mem_addr, .mem_ack, .mem_rdata,
		.brk_mark, .latency);

	// Clock at 10 MHz
	always #50 aclk = ~aclk;

	// Record stack-flag pushes as they happen, so no pulse is missed
	always @(negedge aclk)
		if (sp_push_valid === 1'b1)
		begin
			pushes++;
			last_push = sp_push_value;
		end

	// ----------------------------------------------------------------
	// Expected values and drivers
	// ----------------------------------------------------------------
	function automatic logic [7:0] mbyte(input logic [19:0] a);
		mbyte = (a == BRK_MARK_ADDR) ? brk_mark : (a[7:0] ^ 8'hA5);
	endfunction : mbyte

	function automatic logic [19:0] vec(input logic [19:0] a);
		logic [23:0] t;
		t = {mbyte(a + 20'h2), mbyte(a + 20'h1), mbyte(a)};
		vec = t[19:0];
	endfunction : vec

	task automatic axi_write(input logic [7:0] a, input logic [31:0] v);
		logic ta, tw, tb;
		int i;
		i = 0;
		@(posedge aclk);
		{awvalid, wvalid, bready} <= 3'b111;
		awaddr <= a;
		wdata <= v;
		do
		begin
			@(negedge aclk);
			{ta, tw, tb} = {awvalid & awready, wvalid & wready, bready & bvalid};
			r = bresp;
			@(posedge aclk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			if (tb) bready <= 1'b0;
			i++;
		end while (!tb && i < 100);
		`CHK("bvalid", 1'b1, tb)
	endtask : axi_write

	task automatic axi_read(input logic [7:0] a);
		logic ta, tr;
		int i;
		i = 0;
		@(posedge aclk);
		{arvalid, rready} <= 2'b11;
		araddr <= a;
		do
		begin
			@(negedge aclk);
			{ta, tr} = {arvalid & arready, rready & rvalid};
			{d, r} = {rdata, rresp};
			@(posedge aclk);
			if (ta) arvalid <= 1'b0;
			if (tr) rready <= 1'b0;
			i++;
		end while (!tr && i < 100);
		`CHK("rvalid", 1'b1, tr)
	endtask : axi_read

	task automatic trap(input exec_kind_t k, input int n);
		int i;
		i = 0;
		@(posedge aclk);
		exec_valid <= 1'b1;
		exec_req <= '{k, 6'(n)};
		do
		begin
			@(negedge aclk);
			i++;
		end while (exec_ready !== 1'b1 && i < 300);
		`CHK("exec_ready", 1'b1, exec_ready)
		@(posedge aclk);
		exec_valid <= 1'b0;
	endtask : trap

	task automatic wait_pc(input logic [19:0] exp);
		int i;
		i = 0;
		do
		begin
			@(negedge aclk);
			i++;
		end while (pc_load !== 1'b1 && i < 300);
		`CHK("pc_load", 1'b1, pc_load)
		`CHK("pc_value", exp, pc_value)
	endtask : wait_pc

	task automatic quiet(input int n);
		repeat (n)
		begin
			@(negedge aclk);
			`CHK("pc_load", 1'b0, pc_load)
			`CHK("periph_ack", 1'b0, periph_ack)
		end
	endtask : quiet

	task automatic arith(input logic ov);
		@(posedge aclk);
		{arith_valid, arith_overflow} <= {1'b1, ov};
		@(posedge aclk);
		arith_valid <= 1'b0;
		@(negedge aclk);
		`CHK("overflow_flag", ov, overflow_flag)
	endtask : arith

	task automatic ret(input logic s);
		@(posedge aclk);
		{ret_restore, ret_sp_select} <= {1'b1, s};
		@(posedge aclk);
		ret_restore <= 1'b0;
		@(negedge aclk);
		`CHK("sp_select", s, sp_select)
	endtask : ret

	task automatic fetch(input logic hit);
		@(posedge aclk);
		{fetch_valid, fetch_addr} <= {1'b1, 20'h12345};
		@(negedge aclk);
		`CHK("match_hit", hit, match_hit)
		@(posedge aclk);
		fetch_valid <= 1'b0;
	endtask : fetch

	task automatic done(input string s);
		$display("test %s finished", s);
	endtask : done

	task automatic stop_test;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : stop_test

	// Cut a hang short at 20000 cycles, far past the expected few hundred cycles
	initial
	begin
		#2000000;
		n_fail++;
		stop_test;
	end

	// ----------------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------------
	initial
	begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, exec_valid, arith_valid} = 8'h00;
		{arith_overflow, ret_restore, ret_sp_select, fetch_valid, periph_valid} = 5'h00;
		{debugger_break_interrupt, watchdog_event, single_step_event, global_enable} = 4'h0;
		{awaddr, araddr, wdata, wstrb, exec_req, fetch_addr} = '0;
		{cpu_level, periph_level, periph_number, latency, brk_mark} = {3'h7, 3'h0, 6'h00, 3'h0, 8'h12};
		wstrb = 4'hF;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		wait_pc(vec(20'hFFFFC));
		`CHK("id_byte", mbyte(20'hFFFFF), id_byte)
		done("reset");
		axi_write(OFS_TBASE, {12'h000, tbase});
		`CHK("bresp", RESP_OKAY, r)
		axi_write(OFS_MATCH0, 32'h00012345);
		axi_read(OFS_MATCH0);
		`CHK("match0", 32'h00012345, d)
		axi_write(OFS_STATUS, 32'hFFFFFFFF);
		`CHK("bresp", RESP_OKAY, r)
		axi_read(8'h28);
		`CHK("rresp", RESP_SLVERR, r)
		done("registers");
		// Enable off and level at maximum: instruction traps still go through
		trap(EX_UND, 0);
		wait_pc(vec(FIXED_BASE));
		arith(1'b1);
		arith(1'b0);
		trap(EX_OVF, 0);
		quiet(30);
		arith(1'b1);
		trap(EX_OVF, 0);
		wait_pc(vec(20'hFFFE0));
		latency <= 3'h3;
		trap(EX_BRK, 0);
		wait_pc(vec(20'hFFFE4));
		brk_mark <= 8'hFF;
		trap(EX_BRK, 0);
		wait_pc(vec(tbase));
		done("instruction traps");
		foreach (nums[i])
		begin
			ret(1'b1);
			p = pushes;
			trap(EX_NUM, nums[i]);
			wait_pc(vec(tbase + 20'(nums[i]) * 20'h4));
			`CHK("pushes", p + (nums[i] < 32), pushes)
			`CHK("sp_select", nums[i] >= 32, sp_select)
			if (nums[i] < 32) `CHK("last_push", 1'b1, last_push)
		end
		ret(1'b0);
		done("numbered traps");
		foreach (spec[i])
		begin
			@(posedge aclk);
			{debugger_break_interrupt, watchdog_event, single_step_event} <= 3'b100 >> i;
			@(posedge aclk);
			{debugger_break_interrupt, watchdog_event, single_step_event} <= 3'b000;
			wait_pc(vec(spec[i]));
		end
		fetch(1'b0);
		quiet(20);
		axi_write(OFS_EN_A, 32'h00000001);
		fetch(1'b1);
		wait_pc(vec(20'hFFFE8));
		done("special sources");
		latency <= 3'h0;
		@(posedge aclk);
		cpu_level <= 3'h1;
		{periph_valid, periph_number, periph_level} <= {1'b1, 6'h05, 3'h3};
		quiet(20);
		@(posedge aclk);
		global_enable <= 1'b1;
		p = 0;
		do
		begin
			@(negedge aclk);
			p++;
		end while (periph_ack !== 1'b1 && p < 50);
		`CHK("periph_ack", 1'b1, periph_ack)
		@(posedge aclk);
		periph_valid <= 1'b0;
		wait_pc(vec(tbase + 20'h14));
		@(posedge aclk);
		{periph_valid, periph_level} <= {1'b1, 3'h1};
		quiet(20);
		@(posedge aclk);
		periph_valid <= 1'b0;
		done("peripheral");
		// Mid-run reset: defaults return and the reset vector is fetched again
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		wait_pc(vec(20'hFFFFC));
		axi_read(OFS_TBASE);
		`CHK("tbase", 32'h00000000, d)
		done("mid-run reset");
		stop_test;
	end
endmodule : tb_interrupt_source_vector_unit
`default_nettype wire

// *** sim/vector_memory_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// Vector memory seen by the fetch sequencer
// ----------------------------------------------------------------
module vector_memory_model
	import isvu_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Byte read port
	input wire logic mem_req,
	input wire logic [19:0] mem_addr,
	output logic mem_ack,
	output logic [7:0] mem_rdata,
	// Scenario controls
	input wire logic [7:0] brk_mark,
	input wire logic [2:0] latency
);
	logic [2:0] wait_q;
	// Contents are a pattern of the low address byte, so vectors within one 256-byte window differ
	wire logic [7:0] byte_w = (mem_addr == BRK_MARK_ADDR) ? brk_mark : (mem_addr[7:0] ^ 8'hA5);

	// One byte per acknowledge; data toggles between acks so a stale byte never looks valid
	always_ff @(posedge aclk)
	begin
		mem_ack <= 1'b0;
		mem_rdata <= ~mem_rdata;
		if (!aresetn)
		begin
			wait_q <= 3'h0;
			mem_rdata <= 8'h00;
		end
		else if (mem_req && !mem_ack && wait_q == latency)
		begin
			mem_ack <= 1'b1;
			mem_rdata <= byte_w;
			wait_q <= 3'h0;
		end
		else if (mem_req && !mem_ack)
			wait_q <= wait_q + 3'h1; // Slow answers when latency is raised
	end
endmodule : vector_memory_model
`default_nettype wire
